// ---- design/dsdi_cfg.svh ----
// Register map, field positions and reset values of the descriptor DMA status block
`ifndef DSDI_CFG_SVH
`define DSDI_CFG_SVH

// ********************************
// Register addresses (word index)
// ********************************
`define DSDI_ADDR_W 10
`define DSDI_PTR_CH0 10'h003
`define DSDI_PTR_CH1 10'h007
`define DSDI_PTR_CH2 10'h00B
`define DSDI_PTR_CH3 10'h00F
`define DSDI_STAT_CH0 10'h020
`define DSDI_STAT_CH1 10'h021
`define DSDI_STAT_CH2 10'h022
`define DSDI_STAT_CH3 10'h023
`define DSDI_IRQ_REG 10'h02F

// ********************************
// Status fields
// ********************************
`define DSDI_ST_ERR 0
`define DSDI_ST_IOE 1
`define DSDI_ST_HOE 2
`define DSDI_ST_DONE 3
`define DSDI_ST_SOP 4
`define DSDI_ST_EOP 5
`define DSDI_ST_BUSY 6
`define DSDI_ST_W 7

// ********************************
// Interrupt register fields
// ********************************
`define DSDI_IRQ_EN 0
`define DSDI_IRQ_RX1 28
`define DSDI_IRQ_TX1 29
`define DSDI_IRQ_RX0 30
`define DSDI_IRQ_TX0 31

`define DSDI_ALIGN_MASK 32'h00000007
`define DSDI_NULL_PTR 32'h00000000
`define DSDI_RST_IRQ_EN 1'b0
`define DSDI_RST_FLAGS 4'h0

`endif

// ---- design/dsdi_pkg.sv ----
// Types shared by the descriptor DMA status block
package dsdi_pkg;
  typedef enum logic [1:0] {
    CH_IDLE,
    CH_FETCH,
    CH_XFER,
    CH_WBACK
  } dsdi_state_t;
  typedef logic [6:0] dsdi_status_t;
endpackage

// ---- design/dsdi_top.sv ----
// Four-channel descriptor tracking, status and shared interrupt logic
`timescale 1ns/100ps
`include "dsdi_cfg.svh"
module dsdi_top #(
  parameter int NCH = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [9:0] dcr_addr,
  input wire logic [31:0] dcr_wdata,
  input wire logic dcr_write,
  input wire logic dcr_read,
  output logic dcr_ack,
  output logic [31:0] dcr_rdata,
  output logic [NCH-1:0] fetch_req,
  output logic [NCH-1:0][31:0] desc_ptr,
  input wire logic [NCH-1:0] fetch_done,
  input wire logic [NCH-1:0][31:0] fetch_status,
  input wire logic [NCH-1:0][31:0] fetch_next_ptr,
  input wire logic [NCH-1:0] fetch_buf_ok,
  output logic [NCH-1:0] xfer_run,
  input wire logic [NCH-1:0] len_zero,
  input wire logic [NCH-1:0] client_sop,
  input wire logic [NCH-1:0] client_eop,
  output logic [NCH-1:0] wb_req,
  output logic [NCH-1:0][31:0] wb_status,
  input wire logic [NCH-1:0] wb_done,
  output logic [NCH-1:0] chan_busy,
  output logic irq
);
  import dsdi_pkg::*;

  // ********************************
  // Decode helpers
  // ********************************
  function automatic logic is_ptr_addr(input logic [9:0] a, input int c);
    logic [9:0] base;
    base = 10'(c * 4);
    return a == (base + `DSDI_PTR_CH0);
  endfunction

  function automatic logic is_stat_addr(input logic [9:0] a, input int c);
    return a == (`DSDI_STAT_CH0 + 10'(c));
  endfunction

  function automatic logic misaligned(input logic [31:0] p);
    return (p & `DSDI_ALIGN_MASK) != 32'h00000000;
  endfunction

  // Channel c owns bit 31-c: tx0, rx0, tx1, rx1
  function automatic int irq_bit(input int c);
    return `DSDI_IRQ_TX0 - c;
  endfunction

  function automatic logic is_irq_addr(input logic [9:0] a);
    return a == `DSDI_IRQ_REG;
  endfunction

  // ********************************
  // Bus handshake
  // ********************************
  // Request is held by the master until ack; act once, on the cycle ack rises
  logic wr_go;
  logic rd_go;
  assign wr_go = dcr_write & ~dcr_ack;
  assign rd_go = dcr_read & ~dcr_ack;

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dcr_ack <= 1'b0;
    end
    else
    begin
      dcr_ack <= wr_go | rd_go;
    end
  end

  // ********************************
  // Channel engines
  // ********************************
  dsdi_state_t state [NCH];
  dsdi_status_t status [NCH];
  logic [NCH-1:0][31:0] next_ptr;
  logic [NCH-1:0] irq_pulse;

  genvar c;
  generate
    for (c = 0; c < NCH; c++)
    begin : g_ch
      // Odd channels receive, even channels transmit
      localparam logic IS_RX = (c % 2) == 1;
      logic ptr_wr;
      assign ptr_wr = wr_go & is_ptr_addr(dcr_addr, c);

      always_ff @(posedge clk or negedge rstn)
      begin
        if (!rstn)
        begin
          state[c] <= CH_IDLE;
          status[c] <= 7'h00;
          desc_ptr[c] <= 32'h00000000;
          next_ptr[c] <= 32'h00000000;
          fetch_req[c] <= 1'b0;
          xfer_run[c] <= 1'b0;
          wb_req[c] <= 1'b0;
          wb_status[c] <= 32'h00000000;
          chan_busy[c] <= 1'b0;
          irq_pulse[c] <= 1'b0;
        end
        else
        begin
          irq_pulse[c] <= 1'b0;
          if (ptr_wr && state[c] != CH_IDLE)
          begin
            // Abort: the data path must drop whatever it was doing
            status[c][`DSDI_ST_ERR] <= 1'b1;
            status[c][`DSDI_ST_BUSY] <= 1'b0;
            state[c] <= CH_IDLE;
            fetch_req[c] <= 1'b0;
            xfer_run[c] <= 1'b0;
            wb_req[c] <= 1'b0;
            chan_busy[c] <= 1'b0;
            irq_pulse[c] <= 1'b1;
          end
          else
          begin
            case (state[c])
              CH_IDLE:
              begin
                if (ptr_wr)
                begin
                  desc_ptr[c] <= dcr_wdata;
                  // A bad start pointer never leaves idle, so nothing is fetched from it
                  if (misaligned(dcr_wdata))
                  begin
                    status[c][`DSDI_ST_ERR] <= 1'b1;
                    irq_pulse[c] <= 1'b1;
                  end
                  else
                  begin
                    status[c][`DSDI_ST_ERR] <= 1'b0;
                    status[c][`DSDI_ST_BUSY] <= 1'b1;
                    chan_busy[c] <= 1'b1;
                    fetch_req[c] <= 1'b1;
                    state[c] <= CH_FETCH;
                  end
                end
              end
              CH_FETCH:
              begin
                if (fetch_done[c])
                begin
                  fetch_req[c] <= 1'b0;
                  // Kept until write-back ends; software cannot see it
                  next_ptr[c] <= fetch_next_ptr[c];
                  status[c][`DSDI_ST_IOE] <= fetch_status[c][`DSDI_ST_IOE];
                  status[c][`DSDI_ST_HOE] <= fetch_status[c][`DSDI_ST_HOE];
                  // Receive channels learn packet edges from the client instead
                  status[c][`DSDI_ST_SOP] <= IS_RX ? 1'b0 : fetch_status[c][`DSDI_ST_SOP];
                  status[c][`DSDI_ST_EOP] <= IS_RX ? 1'b0 : fetch_status[c][`DSDI_ST_EOP];
                  wb_status[c] <= fetch_status[c];
                  if (fetch_status[c][`DSDI_ST_DONE] || !fetch_buf_ok[c]
                      || misaligned(fetch_next_ptr[c]))
                  begin
                    // Error is recorded in the descriptor before halting
                    status[c][`DSDI_ST_ERR] <= 1'b1;
                    wb_status[c][`DSDI_ST_ERR] <= 1'b1;
                    wb_req[c] <= 1'b1;
                    state[c] <= CH_WBACK;
                  end
                  else
                  begin
                    xfer_run[c] <= 1'b1;
                    state[c] <= CH_XFER;
                  end
                end
              end
              CH_XFER:
              begin
                if (IS_RX && client_sop[c])
                begin
                  status[c][`DSDI_ST_SOP] <= 1'b1;
                  wb_status[c][`DSDI_ST_SOP] <= 1'b1;
                end
                if (len_zero[c] || (IS_RX && client_eop[c]))
                begin
                  status[c][`DSDI_ST_DONE] <= 1'b1;
                  wb_status[c][`DSDI_ST_DONE] <= 1'b1;
                  if (IS_RX && client_eop[c])
                  begin
                    status[c][`DSDI_ST_EOP] <= 1'b1;
                    wb_status[c][`DSDI_ST_EOP] <= 1'b1;
                  end
                  xfer_run[c] <= 1'b0;
                  wb_req[c] <= 1'b1;
                  state[c] <= CH_WBACK;
                end
              end
              CH_WBACK:
              begin
                if (wb_done[c])
                begin
                  wb_req[c] <= 1'b0;
                  if (status[c][`DSDI_ST_ERR])
                  begin
                    irq_pulse[c] <= 1'b1;
                  end
                  else
                  begin
                    irq_pulse[c] <= status[c][`DSDI_ST_IOE];
                  end
                  // Error and halt win over a valid next pointer
                  if (status[c][`DSDI_ST_ERR] || status[c][`DSDI_ST_HOE]
                      || next_ptr[c] == `DSDI_NULL_PTR)
                  begin
                    status[c][`DSDI_ST_BUSY] <= 1'b0;
                    chan_busy[c] <= 1'b0;
                    state[c] <= CH_IDLE;
                  end
                  else
                  begin
                    desc_ptr[c] <= next_ptr[c];
                    fetch_req[c] <= 1'b1;
                    state[c] <= CH_FETCH;
                  end
                end
              end
              default:
              begin
                state[c] <= CH_IDLE;
              end
            endcase
          end
        end
      end
    end
  endgenerate

  // ********************************
  // Shared interrupt register
  // ********************************
  logic irq_en;
  logic [NCH-1:0] irq_flag;
  logic [NCH-1:0] irq_ack;
  logic irq_wr;
  assign irq_wr = wr_go & is_irq_addr(dcr_addr);

  generate
    for (c = 0; c < NCH; c++)
    begin : g_ack
      assign irq_ack[c] = irq_wr & dcr_wdata[irq_bit(c)];
    end
  endgenerate

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_en <= `DSDI_RST_IRQ_EN;
    end
    else
    begin
      if (irq_wr)
      begin
        irq_en <= dcr_wdata[`DSDI_IRQ_EN];
      end
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq_flag <= `DSDI_RST_FLAGS;
    end
    else
    begin
      // A new request in the acknowledge cycle survives
      irq_flag <= (irq_flag & ~irq_ack) | irq_pulse;
    end
  end

  // ********************************
  // Interrupt output
  // ********************************
  // Built from the flag's next value so the pin rises with the flag, not a cycle later
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      irq <= 1'b0;
    end
    else
    begin
      irq <= irq_en & (|((irq_flag & ~irq_ack) | irq_pulse));
    end
  end

  // ********************************
  // Read data
  // ********************************
  logic [31:0] rd_mux;
  always_comb
  begin
    rd_mux = 32'h00000000;
    for (int i = 0; i < NCH; i++)
    begin
      if (is_ptr_addr(dcr_addr, i))
      begin
        rd_mux = desc_ptr[i];
      end
      if (is_stat_addr(dcr_addr, i))
      begin
        rd_mux = {25'h0, status[i]};
      end
    end
    if (is_irq_addr(dcr_addr))
    begin
      // Flags visible whatever the enable and channel activity
      for (int i = 0; i < NCH; i++)
      begin
        rd_mux[irq_bit(i)] = irq_flag[i];
      end
      rd_mux[`DSDI_IRQ_EN] = irq_en;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      dcr_rdata <= 32'h00000000;
    end
    else
    begin
      // Zero outside the ack cycle so a stale word never reaches the bus
      dcr_rdata <= rd_go ? rd_mux : 32'h00000000;
    end
  end
endmodule // dsdi_top

// ---- tb/dsdi_properties.sv ----
// Port-level checks of the descriptor DMA status block
`timescale 1ns/100ps
`include "dsdi_cfg.svh"
module dsdi_properties #(
  parameter int NCH = 4
) (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [9:0] dcr_addr,
  input wire logic [31:0] dcr_wdata,
  input wire logic dcr_write,
  input wire logic dcr_read,
  input wire logic dcr_ack,
  input wire logic [31:0] dcr_rdata,
  input wire logic [NCH-1:0] fetch_req,
  input wire logic [NCH-1:0][31:0] desc_ptr,
  input wire logic [NCH-1:0] xfer_run,
  input wire logic [NCH-1:0] len_zero,
  input wire logic [NCH-1:0] wb_req,
  input wire logic [NCH-1:0][31:0] wb_status,
  input wire logic [NCH-1:0] chan_busy,
  input wire logic irq
);
  logic en_q;
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  // Shadow of the global enable, since the register itself is not a port
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      en_q <= 1'b0;
    else if (dcr_write && !dcr_ack && dcr_addr == `DSDI_IRQ_REG)
      en_q <= dcr_wdata[`DSDI_IRQ_EN];
  end
  a_ack_single: assert property (dcr_ack |=> !dcr_ack)
    else $error("ack longer than one cycle");
  a_ack_follows_req: assert property ((dcr_read || dcr_write) && !dcr_ack |=> dcr_ack)
    else $error("request not acknowledged");
  a_rdata_idle_zero: assert property (!dcr_ack |-> dcr_rdata == 32'h00000000)
    else $error("read data outside ack");
  a_irq_gated_off: assert property (irq |-> $past(en_q))
    else $error("irq while enable clear");
  a_busy_covers_link: assert property (((fetch_req | xfer_run | wb_req) & ~chan_busy) == '0)
    else $error("link active while not busy");
  a_start_fetches: assert property ($rose(chan_busy[0]) |-> fetch_req[0])
    else $error("busy without fetch");
  a_len_to_wback: assert property (len_zero[0] && xfer_run[0] |=> wb_req[0])
    else $error("no write-back after zero length");
  a_wback_done_bit: assert property ($rose(wb_req[0]) && !wb_status[0][0] |-> wb_status[0][3])
    else $error("write-back without done");
  a_wback_ptr_held: assert property (wb_req[0] && $past(wb_req[0]) |-> $stable(desc_ptr[0]))
    else $error("pointer moved in write-back");
  c_irq_raised: cover property ($rose(irq));
  c_wback: cover property (wb_req[0] ##1 !wb_req[0]);
  c_rx_busy: cover property ($rose(chan_busy[1]));
endmodule // dsdi_properties

bind dsdi_top dsdi_properties #(.NCH(NCH)) i_props (.clk(clk), .rstn(rstn),
  .dcr_addr(dcr_addr), .dcr_wdata(dcr_wdata), .dcr_write(dcr_write), .dcr_read(dcr_read),
  .dcr_ack(dcr_ack), .dcr_rdata(dcr_rdata), .fetch_req(fetch_req), .desc_ptr(desc_ptr),
  .xfer_run(xfer_run), .len_zero(len_zero), .wb_req(wb_req), .wb_status(wb_status),
  .chan_busy(chan_busy), .irq(irq));

// ---- tb/dsdi_mem_model.sv ----
// Memory-side partner answering fetch, transfer and write-back requests
`timescale 1ns/100ps
module dsdi_mem_model (
  input wire logic clk,
  input wire logic rstn,
  input wire logic [3:0] fetch_req,
  input wire logic [3:0][31:0] desc_ptr,
  input wire logic [3:0] xfer_run,
  input wire logic [3:0] wb_req,
  input wire logic [3:0] hold_len,
  output logic [3:0] fetch_done,
  output logic [3:0][31:0] fetch_status,
  output logic [3:0][31:0] fetch_next_ptr,
  output logic [3:0] fetch_buf_ok,
  output logic [3:0] len_zero,
  output logic [3:0] wb_done
);
  logic [3:0][1:0] wait_cnt;
  // Descriptor lives in its own address: flags [13:8], bad buffer [14], next [31:16]
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      {fetch_done, len_zero, wb_done, fetch_buf_ok} <= '0;
      {fetch_status, fetch_next_ptr, wait_cnt} <= '0;
    end
    else
      for (int c = 0; c < 4; c++)
      begin
        {fetch_done[c], len_zero[c], wb_done[c]} <= 3'h0;
        // Released lines toggle so a stale word never looks valid
        fetch_status[c] <= ~fetch_status[c];
        fetch_next_ptr[c] <= ~fetch_next_ptr[c];
        fetch_buf_ok[c] <= ~fetch_buf_ok[c];
        if ((fetch_req[c] | (xfer_run[c] & !hold_len[c]) | wb_req[c])
          && !(fetch_done[c] | len_zero[c] | wb_done[c]))
        begin
          if (wait_cnt[c] != 2'h0)
            wait_cnt[c] <= wait_cnt[c] - 2'h1;
          else
          begin
            wait_cnt[c] <= 2'($urandom_range(2, 0));
            {fetch_done[c], len_zero[c], wb_done[c]} <= {fetch_req[c], xfer_run[c], wb_req[c]};
            fetch_status[c] <= {26'h0, desc_ptr[c][13:8]};
            fetch_next_ptr[c] <= {16'h0, desc_ptr[c][31:16]};
            fetch_buf_ok[c] <= !desc_ptr[c][14];
          end
        end
      end
  end
endmodule // dsdi_mem_model

// ---- tb/dsdi_top_tb.sv ----
// Self-checking bench of the descriptor DMA status block
`timescale 1ns/100ps
`include "dsdi_cfg.svh"
module dsdi_top_tb;
  logic clk = 1'b0;
  logic rstn = 1'b0;
  logic [9:0] dcr_addr = '0;
  logic [31:0] dcr_wdata = '0;
  logic dcr_write = 1'b0;
  logic dcr_read = 1'b0;
  logic dcr_ack, irq;
  logic [31:0] dcr_rdata;
  logic [3:0] fetch_req, fetch_done, fetch_buf_ok, xfer_run, len_zero, wb_req, wb_done;
  logic [3:0] chan_busy, hold_len = '0, client_sop = '0, client_eop = '0;
  logic [3:0][31:0] desc_ptr, fetch_status, fetch_next_ptr, wb_status;
  logic [63:0] exp_q[$];
  logic [63:0] w;
  int fails = 0;
  int tests_run = 0;
  int cycles = 0;
  int n;
  always #20 clk = ~clk;
  dsdi_top #(.NCH(4)) i_dut (.clk(clk), .rstn(rstn), .dcr_addr(dcr_addr),
    .dcr_wdata(dcr_wdata), .dcr_write(dcr_write), .dcr_read(dcr_read), .dcr_ack(dcr_ack),
    .dcr_rdata(dcr_rdata), .fetch_req(fetch_req), .desc_ptr(desc_ptr),
    .fetch_done(fetch_done), .fetch_status(fetch_status), .fetch_next_ptr(fetch_next_ptr),
    .fetch_buf_ok(fetch_buf_ok), .xfer_run(xfer_run), .len_zero(len_zero),
    .client_sop(client_sop), .client_eop(client_eop), .wb_req(wb_req),
    .wb_status(wb_status), .wb_done(wb_done), .chan_busy(chan_busy), .irq(irq));
  dsdi_mem_model i_mem (.clk(clk), .rstn(rstn), .fetch_req(fetch_req), .desc_ptr(desc_ptr),
    .xfer_run(xfer_run), .wb_req(wb_req), .hold_len(hold_len), .fetch_done(fetch_done),
    .fetch_status(fetch_status), .fetch_next_ptr(fetch_next_ptr),
    .fetch_buf_ok(fetch_buf_ok), .len_zero(len_zero), .wb_done(wb_done));
  // ****************
  // Tasks
  // ****************
  task automatic compare(input logic [31:0] e, input logic [31:0] g, input logic [31:0] m);
    tests_run++;
    if ((g & m) !== (e & m))
    begin
      fails++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic test_done;
    fails += exp_q.size();
    $display("comparisons %0d mismatches %0d", tests_run, fails);
    if (fails == 0 && tests_run > 0)
      $display("Finished cleanly");
    else
      $display("Finished with errors");
    $finish;
  endtask
  // Request held through the ack edge; the design ignores it there
  task automatic bus(input logic [9:0] a, input logic [31:0] d, input logic r);
    int k = 0;
    @(negedge clk);
    {dcr_addr, dcr_wdata, dcr_read, dcr_write} = {a, d, r, !r};
    while (dcr_ack !== 1'b1 && k < 20)
    begin
      @(negedge clk);
      k++;
    end
    @(negedge clk);
    {dcr_read, dcr_write} = 2'b00;
  endtask
  task automatic rd(input logic [9:0] a, input logic [31:0] e, input logic [31:0] m);
    exp_q.push_back({m, e});
    bus(a, 32'h0, 1'b1);
  endtask
  task automatic run(input int c, input logic [31:0] p);
    int k = 0;
    bus(`DSDI_PTR_CH0 + 10'(4 * c), p, 1'b0);
    repeat (2) @(negedge clk);
    while (chan_busy[c] === 1'b1 && k < 300)
    begin
      @(negedge clk);
      k++;
    end
  endtask
  always @(posedge clk)
  begin
    cycles++;
    if (dcr_ack && dcr_read && exp_q.size() > 0)
    begin
      w = exp_q.pop_front();
      compare(w[31:0], dcr_rdata, w[63:32]);
    end
    if (cycles == 20000)
    begin
      fails++;
      $display("mismatch at %0t: timeout", $time);
      test_done();
    end
  end
  initial
  begin
    void'($urandom(32'hFAB2));
    repeat (2) @(posedge clk);
    @(negedge clk) rstn = 1'b1;
    for (int c = 0; c < 4; c++)
      rd(`DSDI_STAT_CH0 + 10'(c), 32'h0, 32'hFFFFFFFF);
    rd(`DSDI_IRQ_REG, 32'h0, 32'hFFFFFFFF);
    rd(10'h3F0, 32'h0, 32'hFFFFFFFF);
    $display("test reset done");
    for (int c = 0; c < 4; c++)
    begin
      bus(`DSDI_PTR_CH0 + 10'(4 * c), ($urandom & 32'hFFF8) | (1 + $urandom % 7), 1'b0);
      rd(`DSDI_STAT_CH0 + 10'(c), 32'h1, 32'h41);
    end
    rd(`DSDI_IRQ_REG, 32'hF0000000, 32'hFFFFFFFF);
    bus(`DSDI_IRQ_REG, 32'hF0000000, 1'b0);
    rd(`DSDI_IRQ_REG, 32'h0, 32'hFFFFFFFF);
    $display("test misaligned done");
    bus(`DSDI_IRQ_REG, 32'h1, 1'b0);
    run(0, 32'h00000200);
    rd(`DSDI_STAT_CH0, 32'h0A, 32'h7F);
    compare(32'h1, {31'h0, irq}, 32'h1);
    rd(`DSDI_IRQ_REG, 32'h80000001, 32'hFFFFFFFF);
    bus(`DSDI_IRQ_REG, 32'h80000001, 1'b0);
    @(negedge clk);
    compare(32'h0, {31'h0, irq}, 32'h1);
    bus(`DSDI_IRQ_REG, 32'h0, 1'b0);
    run(2, 32'h00000200);
    compare(32'h0, {31'h0, irq}, 32'h1);
    rd(`DSDI_IRQ_REG, 32'h20000000, 32'hFFFFFFFF);
    bus(`DSDI_IRQ_REG, 32'h20000000, 1'b0);
    $display("test completion irq done");
    run(0, 32'h06000000);
    compare(32'h00000600, desc_ptr[0], 32'hFFFFFFFF);
    run(0, 32'h00080600);
    compare(32'h00080600, desc_ptr[0], 32'hFFFFFFFF);
    run(2, 32'h00080400);
    rd(`DSDI_IRQ_REG, 32'h80000000, 32'hFFFFFFFF);
    bus(`DSDI_IRQ_REG, 32'h80000000, 1'b0);
    run(2, 32'h00003000);
    rd(`DSDI_STAT_CH2, 32'h38, 32'h7F);
    $display("test chain halt done");
    for (int i = 0; i < 3; i++)
    begin
      run(3, i == 0 ? 32'h00000800 : (i == 1 ? 32'h00004000 : 32'h00040000));
      rd(`DSDI_STAT_CH3, 32'h1, 32'h41);
      rd(`DSDI_IRQ_REG, 32'h10000000, 32'hFFFFFFFF);
      bus(`DSDI_IRQ_REG, 32'h10000000, 1'b0);
    end
    $display("test fetch errors done");
    hold_len = 4'h1;
    bus(`DSDI_PTR_CH0, 32'h00080000, 1'b0);
    rd(`DSDI_STAT_CH0, 32'h40, 32'h40);
    rd(`DSDI_IRQ_REG, 32'h0, 32'hF0000000);
    bus(`DSDI_PTR_CH0, 32'h00000010, 1'b0);
    repeat (3) @(negedge clk);
    rd(`DSDI_STAT_CH0, 32'h1, 32'h41);
    rd(`DSDI_IRQ_REG, 32'h80000000, 32'hFFFFFFFF);
    bus(`DSDI_IRQ_REG, 32'h80000000, 1'b0);
    {hold_len, n} = {4'h2, 32'h0};
    bus(`DSDI_PTR_CH1, 32'h00000020, 1'b0);
    while (xfer_run[1] !== 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    {client_sop, client_eop} = 8'h22;
    @(negedge clk);
    {client_sop, client_eop, hold_len} = 12'h0;
    n = 0;
    // Wait for write-back; a pointer write here would be a busy-write error
    while (chan_busy[1] === 1'b1 && n < 50)
    begin
      @(negedge clk);
      n++;
    end
    rd(`DSDI_STAT_CH1, 32'h38, 32'h7F);
    $display("test busy and receive done");
    rstn = 1'b0;
    repeat (2) @(negedge clk);
    rstn = 1'b1;
    rd(`DSDI_STAT_CH0, 32'h0, 32'hFFFFFFFF);
    rd(`DSDI_IRQ_REG, 32'h0, 32'hFFFFFFFF);
    $display("test second reset done");
    test_done();
  end
endmodule // dsdi_top_tb
